/* cli_defines.svh */
// constants for the camera link initialization sequencer
// Contract
// RULE_01: deserializer answers at 7-bit address 0x3D
// RULE_02: write 0x01 to register rx_port_select
// RULE_03: write remote_target_id to register backchannel_config
// RULE_04: write 0x30 to register remote_serializer_alias
// RULE_05: write 0x34 to register remote_target_id
// RULE_06: write 0x34 to register remote_target_alias
// RULE_07: write 0x7C to register port_link_config
// RULE_08: write 0x01 to register tx_port_select
// RULE_09: write 0x03 to register csi_output_control
// RULE_10: write 0x03 to register forwarding_arbitration
// RULE_11: write 0x00 to register forwarding_control
// RULE_12: serializer setup goes to address 0x18
// RULE_13: write forwarding_arbitration to ref_clock_divider_m, 0x28 to ref_clock_divider_n
// RULE_14: write 0xF0 to serializer register pin_direction
// RULE_15: write 0x01 to pin_output_value, releasing imager reset
// RULE_16: imager then reachable at address 0x1A
// RULE_17: imager setup only after link setup done
// RULE_18: per camera, select port via 0x3A first
// RULE_19: no writes before all supplies are good
// RULE_20: listed order, single-byte writes, acknowledge required
`ifndef CLI_DEFINES_SVH
`define CLI_DEFINES_SVH

// ----------------------------------------
// target addresses (7-bit)
// ----------------------------------------
`define CLI_ADDR_DESER 7'h3D
`define CLI_ADDR_SER 7'h18
`define CLI_ADDR_IMAGER 7'h1A

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CLI_REG_PORT_SELECT_MULTI 8'h3A
`define CLI_REG_RX_PORT_SELECT 8'h4C
`define CLI_REG_BACKCHANNEL_CONFIG 8'h58
`define CLI_REG_REMOTE_SERIALIZER_ALIAS 8'h5C
`define CLI_REG_REMOTE_TARGET_ID 8'h5D
`define CLI_REG_REMOTE_TARGET_ALIAS 8'h65
`define CLI_REG_PORT_LINK_CONFIG 8'h6D
`define CLI_REG_TX_PORT_SELECT 8'h32
`define CLI_REG_CSI_OUTPUT_CONTROL 8'h33
`define CLI_REG_FORWARDING_ARBITRATION 8'h21
`define CLI_REG_FORWARDING_CONTROL 8'h20
`define CLI_REG_REF_CLOCK_DIVIDER_M 8'h06
`define CLI_REG_REF_CLOCK_DIVIDER_N 8'h07
`define CLI_REG_PIN_DIRECTION 8'h0E
`define CLI_REG_PIN_OUTPUT_VALUE 8'h0D

// ----------------------------------------
// values written
// ----------------------------------------
`define CLI_VAL_RX_PORT_SELECT 8'h01
`define CLI_VAL_BACKCHANNEL_CONFIG 8'h5D
`define CLI_VAL_REMOTE_SERIALIZER_ALIAS 8'h30
`define CLI_VAL_REMOTE_TARGET_ID 8'h34
`define CLI_VAL_REMOTE_TARGET_ALIAS 8'h34
`define CLI_VAL_PORT_LINK_CONFIG 8'h7C
`define CLI_VAL_TX_PORT_SELECT 8'h01
`define CLI_VAL_CSI_OUTPUT_CONTROL 8'h03
`define CLI_VAL_FORWARDING_ARBITRATION 8'h03
`define CLI_VAL_FORWARDING_CONTROL 8'h00
`define CLI_VAL_REF_CLOCK_DIVIDER_M 8'h21
`define CLI_VAL_REF_CLOCK_DIVIDER_N 8'h28
`define CLI_VAL_PIN_DIRECTION 8'hF0
`define CLI_VAL_PIN_OUTPUT_VALUE 8'h01

// ----------------------------------------
// sequence and timing
// ----------------------------------------
`define CLI_STEP_COUNT 5'd15
`define CLI_STEP_W 5
`define CLI_CLK_HZ 125000000
`define CLI_SCL_HZ 1000000
// quarter-bit enable period, rounded up so the clock never beats its nominal rate
`define CLI_QTR_CYCLES ((`CLI_CLK_HZ + `CLI_SCL_HZ * 4 - 1) / (`CLI_SCL_HZ * 4))
`define CLI_QTR_W 10
// longest clock stretch tolerated, in quarter ticks, before a write is abandoned
`define CLI_STALL_LIMIT 10'h3FF
`define CLI_STALL_W 10

`endif

/* cli_pkg.sv */
// types for the camera link initialization sequencer
package cli_pkg;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] reg_addr;
        logic [7:0] data;
    } cli_write_s;

    typedef struct packed {
        logic scl_in;
        logic sda_in;
    } cli_pins_in_s;

    typedef struct packed {
        logic scl_out;
        logic scl_oe_n;
        logic sda_out;
        logic sda_oe_n;
    } cli_pins_out_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic error;
        logic [4:0] step;
        logic [1:0] port;
    } cli_status_s;

    typedef enum logic [6:0] {
        CLI_IDLE = 7'b0000001,
        CLI_START = 7'b0000010,
        CLI_BITS = 7'b0000100,
        CLI_ACK = 7'b0001000,
        CLI_STOP = 7'b0010000,
        CLI_DONE = 7'b0100000,
        CLI_FAIL = 7'b1000000
    } cli_state_e;

endpackage : cli_pkg

/* cli_init.sv */
// i2c initialization sequencer for the coax camera link, host side
`include "cli_defines.svh"

module cli_init (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_good,
    input wire logic start,
    input wire logic [1:0] port_sel,
    input wire cli_pkg::cli_pins_in_s pins_in,
    output cli_pkg::cli_pins_out_s pins_out,
    output cli_pkg::cli_status_s status,
    output logic imager_ready
);
    import cli_pkg::*;

    // ----------------------------------------
    // write table
    // ----------------------------------------
    function automatic cli_write_s step_entry(input logic [4:0] idx, input logic [1:0] port);
        cli_write_s w;
        w.addr = `CLI_ADDR_DESER; // RULE_01
        w.reg_addr = 8'h00;
        w.data = 8'h00;
        unique case (idx)
            5'd0: begin
                // select the camera port first so later writes land on it
                w.reg_addr = `CLI_REG_PORT_SELECT_MULTI; // RULE_18
                w.data = {6'h00, port};
            end
            5'd1: begin
                w.reg_addr = `CLI_REG_RX_PORT_SELECT; // RULE_02
                w.data = `CLI_VAL_RX_PORT_SELECT;
            end
            5'd2: begin
                w.reg_addr = `CLI_REG_BACKCHANNEL_CONFIG; // RULE_03
                w.data = `CLI_VAL_BACKCHANNEL_CONFIG;
            end
            5'd3: begin
                w.reg_addr = `CLI_REG_REMOTE_SERIALIZER_ALIAS; // RULE_04
                w.data = `CLI_VAL_REMOTE_SERIALIZER_ALIAS;
            end
            5'd4: begin
                w.reg_addr = `CLI_REG_REMOTE_TARGET_ID; // RULE_05
                w.data = `CLI_VAL_REMOTE_TARGET_ID;
            end
            5'd5: begin
                w.reg_addr = `CLI_REG_REMOTE_TARGET_ALIAS; // RULE_06
                w.data = `CLI_VAL_REMOTE_TARGET_ALIAS;
            end
            5'd6: begin
                w.reg_addr = `CLI_REG_PORT_LINK_CONFIG; // RULE_07
                w.data = `CLI_VAL_PORT_LINK_CONFIG;
            end
            5'd7: begin
                w.reg_addr = `CLI_REG_TX_PORT_SELECT; // RULE_08
                w.data = `CLI_VAL_TX_PORT_SELECT;
            end
            5'd8: begin
                w.reg_addr = `CLI_REG_CSI_OUTPUT_CONTROL; // RULE_09
                w.data = `CLI_VAL_CSI_OUTPUT_CONTROL;
            end
            5'd9: begin
                w.reg_addr = `CLI_REG_FORWARDING_ARBITRATION; // RULE_10
                w.data = `CLI_VAL_FORWARDING_ARBITRATION;
            end
            5'd10: begin
                w.reg_addr = `CLI_REG_FORWARDING_CONTROL; // RULE_11
                w.data = `CLI_VAL_FORWARDING_CONTROL;
            end
            5'd11: begin
                w.addr = `CLI_ADDR_SER; // RULE_12
                w.reg_addr = `CLI_REG_REF_CLOCK_DIVIDER_M; // RULE_13
                w.data = `CLI_VAL_REF_CLOCK_DIVIDER_M;
            end
            5'd12: begin
                w.addr = `CLI_ADDR_SER;
                w.reg_addr = `CLI_REG_REF_CLOCK_DIVIDER_N; // RULE_13
                w.data = `CLI_VAL_REF_CLOCK_DIVIDER_N;
            end
            5'd13: begin
                w.addr = `CLI_ADDR_SER;
                w.reg_addr = `CLI_REG_PIN_DIRECTION; // RULE_14
                w.data = `CLI_VAL_PIN_DIRECTION;
            end
            5'd14: begin
                w.addr = `CLI_ADDR_SER;
                w.reg_addr = `CLI_REG_PIN_OUTPUT_VALUE; // RULE_15
                w.data = `CLI_VAL_PIN_OUTPUT_VALUE;
            end
            default: begin
                w.addr = `CLI_ADDR_DESER;
            end
        endcase
        return w;
    endfunction : step_entry

    // ----------------------------------------
    // quarter-bit enable divider
    // ----------------------------------------
    localparam logic [`CLI_QTR_W-1:0] QTR_LAST = `CLI_QTR_W'(`CLI_QTR_CYCLES - 1);
    logic [`CLI_QTR_W-1:0] div_q, div_d;
    logic tick;

    always_comb begin
        tick = (div_q == QTR_LAST);
        div_d = tick ? '0 : div_q + `CLI_QTR_W'(1);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= '0;
        end else begin
            div_q <= div_d;
        end
    end

    // ----------------------------------------
    // sequencer and bit engine
    // ----------------------------------------
    cli_state_e state_q, state_d;
    logic [4:0] step_q, step_d;
    logic [1:0] byte_q, byte_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] phase_q, phase_d;
    logic [1:0] port_q, port_d;
    logic scl_q, scl_d;
    logic sda_q, sda_d;
    logic ready_q, ready_d;
    cli_write_s cur;
    logic [7:0] cur_byte;

    always_comb begin
        cur = step_entry(step_q, port_q);
        unique case (byte_q)
            2'd0: cur_byte = {cur.addr, 1'b0};
            2'd1: cur_byte = cur.reg_addr;
            default: cur_byte = cur.data;
        endcase
    end

    // ----------------------------------------
    // clock stretch watch
    // ----------------------------------------
    // a target may hold the clock low: phases wait for it, but a stuck wire
    // must not hang the sequence, so a long stall abandons the write
    logic stretch;
    logic adv;
    logic stall_over;
    logic [`CLI_STALL_W-1:0] stall_q, stall_d;

    always_comb begin
        stretch = scl_q && !pins_in.scl_in;
        adv = tick && !stretch;
        stall_over = (stall_q == `CLI_STALL_LIMIT);
        stall_d = '0;
        if (stretch) begin
            stall_d = stall_q;
            if (tick && !stall_over) begin
                stall_d = stall_q + `CLI_STALL_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stall_q <= '0;
        end else begin
            stall_q <= stall_d;
        end
    end

    always_comb begin
        state_d = state_q;
        step_d = step_q;
        byte_d = byte_q;
        bit_d = bit_q;
        phase_d = phase_q;
        port_d = port_q;
        scl_d = scl_q;
        sda_d = sda_q;
        ready_d = ready_q;
        unique case (state_q)
            CLI_IDLE: begin
                scl_d = 1'b1;
                sda_d = 1'b1;
                if (start && power_good) begin // RULE_19
                    port_d = port_sel;
                    step_d = '0;
                    ready_d = 1'b0;
                    phase_d = '0;
                    state_d = CLI_START;
                end
            end
            CLI_START: begin
                if (adv) begin
                    phase_d = phase_q + 2'd1;
                    unique case (phase_q)
                        2'd0: sda_d = 1'b0;
                        2'd1: scl_d = 1'b0;
                        2'd2: begin
                        end
                        default: begin
                            byte_d = '0;
                            bit_d = 3'd7;
                            phase_d = '0;
                            state_d = CLI_BITS;
                        end
                    endcase
                end
            end
            CLI_BITS: begin
                if (adv) begin
                    phase_d = phase_q + 2'd1;
                    unique case (phase_q)
                        2'd0: sda_d = cur_byte[bit_q];
                        2'd1: scl_d = 1'b1;
                        2'd2: begin
                        end
                        default: begin
                            scl_d = 1'b0;
                            bit_d = bit_q - 3'd1;
                            if (bit_q == 3'd0) begin
                                state_d = CLI_ACK;
                            end
                        end
                    endcase
                end
            end
            CLI_ACK: begin
                if (adv) begin
                    phase_d = phase_q + 2'd1;
                    unique case (phase_q)
                        2'd0: sda_d = 1'b1;
                        2'd1: scl_d = 1'b1;
                        2'd2: begin
                            // nack aborts the whole sequence
                            if (pins_in.sda_in) begin // RULE_20
                                state_d = CLI_FAIL;
                                scl_d = 1'b1;
                            end
                        end
                        default: begin
                            scl_d = 1'b0;
                            sda_d = 1'b0;
                            phase_d = '0;
                            if (byte_q == 2'd2) begin
                                state_d = CLI_STOP;
                            end else begin
                                byte_d = byte_q + 2'd1;
                                bit_d = 3'd7;
                                state_d = CLI_BITS;
                            end
                        end
                    endcase
                end
            end
            CLI_STOP: begin
                if (adv) begin
                    phase_d = phase_q + 2'd1;
                    unique case (phase_q)
                        2'd0: sda_d = 1'b0;
                        2'd1: scl_d = 1'b1;
                        2'd2: sda_d = 1'b1;
                        default: begin
                            phase_d = '0;
                            if (step_q == `CLI_STEP_COUNT - 5'd1) begin
                                state_d = CLI_DONE;
                            end else begin
                                step_d = step_q + 5'd1; // RULE_20
                                state_d = CLI_START;
                            end
                        end
                    endcase
                end
            end
            CLI_DONE: begin
                // imager traffic may only follow once every link write is acked
                ready_d = 1'b1; // RULE_17 RULE_16
                if (start && power_good) begin
                    port_d = port_sel;
                    step_d = '0;
                    ready_d = 1'b0;
                    state_d = CLI_START;
                end
            end
            CLI_FAIL: begin
                scl_d = 1'b1;
                sda_d = 1'b1;
                if (start && power_good) begin
                    port_d = port_sel;
                    step_d = '0;
                    phase_d = '0;
                    state_d = CLI_START;
                end
            end
            default: state_d = CLI_IDLE;
        endcase
        if (stall_over && status.busy) begin
            state_d = CLI_FAIL;
            scl_d = 1'b1;
            sda_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= CLI_IDLE;
            step_q <= '0;
            byte_q <= '0;
            bit_q <= 3'd7;
            phase_q <= '0;
            port_q <= '0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            step_q <= step_d;
            byte_q <= byte_d;
            bit_q <= bit_d;
            phase_q <= phase_d;
            port_q <= port_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            ready_q <= ready_d;
        end
    end

    // ----------------------------------------
    // pins and status
    // ----------------------------------------
    // open drain: enable low pulls the wire low, released otherwise
    assign pins_out.scl_out = 1'b0;
    assign pins_out.sda_out = 1'b0;
    assign pins_out.scl_oe_n = scl_q;
    assign pins_out.sda_oe_n = sda_q;
    assign status.busy = !(state_q inside {CLI_IDLE, CLI_DONE, CLI_FAIL});
    assign status.done = (state_q == CLI_DONE);
    assign status.error = (state_q == CLI_FAIL);
    assign status.step = step_q;
    assign status.port = port_q;
    assign imager_ready = ready_q;

endmodule : cli_init

/* cli_init_chk.sv */
// assertion checker for the camera link initialization sequencer
module cli_init_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_good,
    input wire logic start,
    input wire logic [1:0] port_sel,
    input wire cli_pkg::cli_pins_in_s pins_in,
    input wire cli_pkg::cli_pins_out_s pins_out,
    input wire cli_pkg::cli_status_s status,
    input wire logic imager_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import cli_pkg::*;
    logic [9:0] gap_q;
    logic [9:0] gap_d;
    logic scl_last_q;
    logic scl_last_d;
    // ----------------------------------------
    // clock edge spacing
    // ----------------------------------------
    // saturates so that a long idle never wraps into a short gap
    always_comb begin
        scl_last_d = pins_out.scl_oe_n;
        gap_d = (gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001;
        if (pins_out.scl_oe_n != scl_last_q) begin
            gap_d = 10'h000;
        end
        if (reset) begin
            gap_d = 10'h3FF;
            scl_last_d = 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        gap_q <= gap_d;
        scl_last_q <= scl_last_d;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_BUS_FREE_IDLE: assert property (!status.busy |-> pins_out.scl_oe_n && pins_out.sda_oe_n)
        else $error("bus held while idle");
    AST_UNPOWERED: assert property (!status.busy && !power_good |=> !status.busy)
        else $error("started without power");
    AST_TAKE: assert property (!status.busy && start && power_good |=> status.busy)
        else $error("start not taken");
    AST_READY_AFTER_DONE: assert property ($rose(status.done) && !(start && power_good) |=> imager_ready)
        else $error("imager ready late");
    AST_READY_NEEDS_DONE: assert property (imager_ready |-> status.done && !status.busy)
        else $error("imager ready early");
    AST_EXCL: assert property (status.busy |-> !status.done && !status.error)
        else $error("busy with done or error");
    AST_STEP: assert property (status.step <= 5'h0E)
        else $error("step out of range");
    AST_PORT_HELD: assert property (status.busy && $past(status.busy) |-> $stable(status.port))
        else $error("port changed mid run");
    AST_OPEN_DRAIN: assert property (!pins_out.scl_out && !pins_out.sda_out)
        else $error("pin driven high");
    // clock edges are at least two quarter ticks of 32 cycles apart
    AST_QUARTER: assert property ($changed(pins_out.scl_oe_n) && status.busy |-> gap_q >= 10'd63)
        else $error("clock edge too soon");
    AST_FAIL_HOLDS: assert property (status.error && !start |=> status.error)
        else $error("error dropped");
    AST_DONE_HOLDS: assert property (status.done && !start ##1 !start |-> status.done ##1 status.done)
        else $error("done dropped");
endmodule : cli_init_chk

bind cli_init cli_init_chk u_cli_init_chk (.clk_sys(clk_sys), .reset(reset),
    .power_good(power_good), .start(start), .port_sel(port_sel), .pins_in(pins_in),
    .pins_out(pins_out), .status(status), .imager_ready(imager_ready));

/* cli_dev_model.sv */
// behavioural model of the deserializer and serializer register ports
module cli_dev_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] refuse_addr,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    import cli_pkg::*;
    logic [7:0] deser_reg [256];
    logic [7:0] ser_reg [256];
    cli_write_s wr_log [$];
    cli_write_s cur;
    logic [7:0] sh;
    logic hit;
    int nbit;
    int nbyte;
    function automatic logic ack_ok(input logic [6:0] a);
        if (a == refuse_addr) return 1'b0;
        if (a == 7'h3D) return 1'b1;
        if (a == deser_reg[8'h5C][7:1]) return 1'b1;
        return a == deser_reg[8'h65][7:1] && ser_reg[8'h0D][0];
    endfunction : ack_ok
    // ----------------------------------------
    // target byte engine
    // ----------------------------------------
    initial begin
        sda_pull = 1'b0;
        nbit = 99;
        nbyte = 0;
        hit = 1'b0;
        cur = '0;
        sh = 8'h00;
        foreach (deser_reg[i]) begin
            deser_reg[i] = 8'h00;
            ser_reg[i] = 8'h00;
        end
    end
    always @(negedge sda) if (scl === 1'b1) begin
        nbit = -1;
        nbyte = 0;
    end
    always @(posedge sda) if (scl === 1'b1) nbit = 99;
    always @(posedge scl) if (nbit >= 0 && nbit < 8) sh = {sh[6:0], sda};
    always @(negedge scl) begin
        nbit = nbit + 1;
        if (nbit == 8) begin
            if (nbyte == 0) begin
                cur.addr = sh[7:1];
                hit = !sh[0] && ack_ok(sh[7:1]);
            end else if (nbyte == 1) begin
                cur.reg_addr = sh;
            end else if (nbyte == 2 && hit) begin
                cur.data = sh;
                wr_log.push_back(cur);
                if (cur.addr == 7'h3D) deser_reg[cur.reg_addr] = sh;
                else ser_reg[cur.reg_addr] = sh;
            end
            // extra bytes are refused: single-byte writes only
            sda_pull = hit && nbyte < 3;
            nbyte = nbyte + 1;
        end else if (nbit == 9) begin
            sda_pull = 1'b0;
            nbit = 0;
        end
    end
endmodule : cli_dev_model

/* test_camera_link_i2c_init.sv */
// self-checking bench for the camera link initialization sequencer
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module test_camera_link_i2c_init;
    timeunit 1ns;
    timeprecision 1ps;
    import cli_pkg::*;
    logic clk_sys;
    logic reset;
    logic power_good;
    logic start;
    logic [1:0] port_sel;
    logic [1:0] port;
    logic [6:0] refuse;
    logic sda_pull;
    logic [31:0] rnd;
    int err_total = 0;
    int num_checks = 0;
    cli_pins_in_s pins_in;
    cli_pins_out_s pins_out;
    cli_status_s status;
    logic imager_ready;
    // ----------------------------------------
    // wiring and helpers
    // ----------------------------------------
    // both lines have pull-ups; the devices never stretch the clock
    assign pins_in = '{scl_in: pins_out.scl_oe_n, sda_in: pins_out.sda_oe_n & ~sda_pull};
    cli_init u_cli_init (.clk_sys(clk_sys), .reset(reset), .power_good(power_good),
        .start(start), .port_sel(port_sel), .pins_in(pins_in), .pins_out(pins_out),
        .status(status), .imager_ready(imager_ready));
    cli_dev_model u_cli_dev_model (.scl(pins_in.scl_in), .sda(pins_in.sda_in),
        .refuse_addr(refuse), .sda_pull(sda_pull));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    function automatic cli_write_s exp_wr(input int i, input logic [1:0] p);
        logic [7:0] r [15] = '{8'h3A, 8'h4C, 8'h58, 8'h5C, 8'h5D, 8'h65, 8'h6D, 8'h32,
            8'h33, 8'h21, 8'h20, 8'h06, 8'h07, 8'h0E, 8'h0D};
        logic [7:0] v [15] = '{8'h00, 8'h01, 8'h5D, 8'h30, 8'h34, 8'h34, 8'h7C, 8'h01,
            8'h03, 8'h03, 8'h00, 8'h21, 8'h28, 8'hF0, 8'h01};
        return '{(i < 11) ? 7'h3D : 7'h18, r[i], (i == 0) ? {6'h00, p} : v[i]};
    endfunction : exp_wr
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    task automatic kick;
        @(posedge clk_sys);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        `CHK(status.busy, 1'b1)
    endtask : kick
    task automatic wait_idle(input int limit);
        int n = 0;
        while (status.busy !== 1'b0 && n < limit) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= limit) begin
            err_total++;
            $display("Error at %0t: sequence hung", $time);
        end
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : wait_idle
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rnd = 32'h0000A082;
        reset = 1'b1;
        power_good = 1'b0;
        start = 1'b0;
        port_sel = 2'h0;
        port = 2'h0;
        refuse = 7'h7F;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        #1;
        `CHK({status.busy, status.done, status.error, imager_ready}, 4'h0)
        rnd = lfsr(rnd);
        @(posedge clk_sys);
        start <= 1'b1;
        for (int i = 0; i < 4 + rnd[3:0]; i++) begin
            @(posedge clk_sys);
            #1;
            `CHK({status.busy, pins_out.sda_oe_n, pins_out.scl_oe_n}, 3'h3)
        end
        @(posedge clk_sys);
        start <= 1'b0;
        power_good <= 1'b1;
        refuse <= 7'h3D;
        kick();
        wait_idle(5000);
        `CHK({status.error, status.done, imager_ready}, 3'h4)
        `CHK(u_cli_dev_model.wr_log.size(), 0)
        rnd = lfsr(rnd);
        port = rnd[1:0];
        @(posedge clk_sys);
        refuse <= 7'h7F;
        port_sel <= port;
        kick();
        // a second start and a new port while busy must both be ignored
        repeat (2 + rnd[7:4]) @(posedge clk_sys);
        start <= 1'b1;
        port_sel <= ~port;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        `CHK(status.port, port)
        wait_idle(70000);
        `CHK({status.done, status.error, imager_ready}, 3'h5)
        `CHK(u_cli_dev_model.wr_log.size(), 15)
        for (int i = 0; i < 15; i++) begin
            `CHK(u_cli_dev_model.wr_log[i], exp_wr(i, port))
        end
        `CHK(u_cli_dev_model.ser_reg[8'h0D][0], 1'b1)
        end_sim();
    end
endmodule : test_camera_link_i2c_init
